//--- src/rftx_outsel.v
`timescale 1ns/1ps
`default_nettype none
// Per-output carrier polarity choice, registered
module rftx_outsel (
  // Clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // Mode and settings
  input wire i_card_mode,
  input wire i_inv_reader,
  input wire i_inv_card,
  // Result
  output reg o_invert
);
  // Only the setting of the current mode counts
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_invert <= 1'b0;
    end else if (i_card_mode) begin
      o_invert <= i_inv_card;
    end else begin
      o_invert <= i_inv_reader;
    end
  end
endmodule
`default_nettype wire

//--- src/rftx_regs.vh
// Summary of operation
// - Bits 19:10 hold reader static gain.
// - Bits 9:0 hold card static gain.
// - Bit 26 picks both or single driver.
// - Bits 25:24 set card carrier amplitude.
// - Bits 23:19 give overshoot residual carrier.
// - Bit 18 forces maximum pump in card mode, overriding amplitude.
// - Bits 17:13 normal residual; 0 full carrier.
// - Bit 12 bypasses shaping, kills rise control.
// - Bits 11:8 set regulator slew, both edges.
// - Fall/rise constants apply only in single-pump mode.
// - Clock bit 18 enables active load modulation in card mode.
// - Bits 13:11 set recovered clock phase, 45-degree steps.
// - Bits 10:8 give clock mode during prevention.
// - Bits 7,5 invert outputs in reader mode.
// - Bits 6,4 invert outputs in card mode.
// - Bits 3:1 choose reader transmitter state.
// - Read-only bit reports PLL enabled and locked.
// - Select bit picks card or reader gain.
`ifndef RFTX_REGS_VH
`define RFTX_REGS_VH

// Register offsets
`define RFTX_OFS_STATUS 8'h1D
`define RFTX_OFS_GAIN_CFG 8'h1E
`define RFTX_OFS_GAIN 8'h1F
`define RFTX_OFS_SHAPE 8'h20
`define RFTX_OFS_CLK 8'h21

// Stored bit masks; everything else is reserved, except the write-only load bit 2 of the gain config
`define RFTX_MASK_GAIN_CFG 32'h0000_0008
`define RFTX_MASK_GAIN 32'h000F_FFFF
`define RFTX_MASK_SHAPE 32'h07FF_FFFF
`define RFTX_MASK_CLK 32'h0004_3FFF

// Reset values
`define RFTX_RST_GAIN_CFG 32'h0000_0000
`define RFTX_RST_GAIN 32'h0000_0000
`define RFTX_RST_SHAPE 32'h0000_0000
`define RFTX_RST_CLK 32'h0000_0000

// Gain fields
`define RFTX_RM_GAIN_MSB 19
`define RFTX_RM_GAIN_LSB 10
`define RFTX_CM_GAIN_MSB 9
`define RFTX_CM_GAIN_LSB 0
`define RFTX_GAIN_SEL_BIT 3
`define RFTX_GAIN_LOAD_BIT 2
`define RFTX_PLL_STAT_BIT 19

// Shaping fields
`define RFTX_LM_DRV_BIT 26
`define RFTX_AMP_MSB 25
`define RFTX_AMP_LSB 24
`define RFTX_OVRES_MSB 23
`define RFTX_OVRES_LSB 19
`define RFTX_MAXPUMP_BIT 18
`define RFTX_RES_MSB 17
`define RFTX_RES_LSB 13
`define RFTX_BYPASS_BIT 12
`define RFTX_SLEW_MSB 11
`define RFTX_SLEW_LSB 8
`define RFTX_FALL_MSB 7
`define RFTX_FALL_LSB 4
`define RFTX_RISE_MSB 3
`define RFTX_RISE_LSB 0

// Clock fields
`define RFTX_ALM_BIT 18
`define RFTX_PHASE_MSB 13
`define RFTX_PHASE_LSB 11
`define RFTX_PCLK_MSB 10
`define RFTX_PCLK_LSB 8
`define RFTX_INV2_RM_BIT 7
`define RFTX_INV2_CM_BIT 6
`define RFTX_INV1_RM_BIT 5
`define RFTX_INV1_CM_BIT 4
`define RFTX_RCLK_MSB 3
`define RFTX_RCLK_LSB 1
`define RFTX_PLL_EN_BIT 0

// Reader transmitter state codes
`define RFTX_TXST_HIZ 3'h0
`define RFTX_TXST_PUSH 3'h1
`define RFTX_TXST_PULL 3'h2
`define RFTX_TXST_CLK 3'h3

// Synchroniser depth
`define RFTX_SYNC_STAGES 2

`endif

//--- src/rftx_sync.v
`timescale 1ns/1ps
`default_nettype none
// Two-flop level synchroniser for asynchronous analog status
module rftx_sync #(
  parameter W = 3
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // Data
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule
`default_nettype wire

//--- src/rftx_top.v
`timescale 1ns/1ps
`default_nettype none
`include "rftx_regs.vh"
// Transmit control register bank with derived transmitter settings
module rftx_top (
  // Clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // Register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // Operating state from device logic
  input wire i_card_mode,
  input wire i_prev_active,
  input wire i_single_pump,
  // Asynchronous analog status
  input wire i_rf_on,
  input wire i_freq_ok,
  input wire i_pll_locked,
  // Gain control
  output reg [9:0] o_gain_value,
  output reg o_gain_load,
  // Shaping controls
  output reg o_lm_single_driver,
  output reg [1:0] o_card_amp,
  output reg o_card_amp_max,
  output reg [4:0] o_residual,
  output reg o_shaping_bypass,
  output reg [3:0] o_slew_rate,
  output reg [3:0] o_fall_tau,
  output reg o_fall_tau_valid,
  output reg [3:0] o_rise_tau,
  output reg o_rise_tau_valid,
  // Clock controls
  output reg o_alm_active,
  output reg [2:0] o_clk_phase,
  output reg [2:0] o_tx_clk_mode,
  output wire o_tx1_invert,
  output wire o_tx2_invert,
  output reg o_pll_enable,
  output reg o_pll_enabled
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge a write, keeping reserved bits at zero
  function [31:0] merge;
    input [31:0] wdata;
    input [31:0] mask;
    begin
      merge = wdata & mask;
    end
  endfunction

  // Address compare used by the write and load request paths
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Storage

  reg [31:0] gain_cfg_reg;
  reg [31:0] gain_reg;
  reg [31:0] shape_reg;
  reg [31:0] clk_reg;
  reg load_reg;
  reg pll_stat_reg;
  wire [2:0] pll_sync;

  // Decoded fields
  wire gain_source_select;
  wire [9:0] reader_static_gain;
  wire [9:0] card_static_gain;
  wire load_mod_driver_select;
  wire [1:0] card_carrier_amplitude;
  wire [4:0] overshoot_residual_level;
  wire card_max_pump_override;
  wire [4:0] normal_residual;
  wire shaping_bypass;
  wire [3:0] regulator_slew_rate;
  wire [3:0] fall_time_constant;
  wire [3:0] rise_time_constant;
  wire active_load_mod_on;
  wire [2:0] recovered_clock_phase;
  wire [2:0] prevention_clock_mode;
  wire out2_invert_reader;
  wire out2_invert_card;
  wire out1_invert_reader;
  wire out1_invert_card;
  wire [2:0] reader_clock_mode;
  wire pll_enable;

  ////////////////////////////////////////////////////////////////////
  // Register writes

  // Single-cycle write strobe, no wait states
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gain_cfg_reg <= `RFTX_RST_GAIN_CFG;
      gain_reg <= `RFTX_RST_GAIN;
      shape_reg <= `RFTX_RST_SHAPE;
      clk_reg <= `RFTX_RST_CLK;
    end else if (i_wr) begin
      if (hit(i_addr, `RFTX_OFS_GAIN_CFG)) begin
        gain_cfg_reg <= merge(i_wdata, `RFTX_MASK_GAIN_CFG);
      end
      if (hit(i_addr, `RFTX_OFS_GAIN)) begin
        gain_reg <= merge(i_wdata, `RFTX_MASK_GAIN);
      end
      if (hit(i_addr, `RFTX_OFS_SHAPE)) begin
        shape_reg <= merge(i_wdata, `RFTX_MASK_SHAPE);
      end
      if (hit(i_addr, `RFTX_OFS_CLK)) begin
        clk_reg <= merge(i_wdata, `RFTX_MASK_CLK);
      end
    end
  end

  // Load request is write-only and clears itself after one cycle
  // Taken straight from the write data, so the bit never reads back
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= i_wr & hit(i_addr, `RFTX_OFS_GAIN_CFG) &
        i_wdata[`RFTX_GAIN_LOAD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Field decode

  // Gain fields
  assign gain_source_select = gain_cfg_reg[`RFTX_GAIN_SEL_BIT];
  assign reader_static_gain = gain_reg[`RFTX_RM_GAIN_MSB:`RFTX_RM_GAIN_LSB];
  assign card_static_gain = gain_reg[`RFTX_CM_GAIN_MSB:`RFTX_CM_GAIN_LSB];

  // Shaping fields
  assign load_mod_driver_select = shape_reg[`RFTX_LM_DRV_BIT];
  assign card_carrier_amplitude = shape_reg[`RFTX_AMP_MSB:`RFTX_AMP_LSB];
  assign overshoot_residual_level = shape_reg[`RFTX_OVRES_MSB:`RFTX_OVRES_LSB];
  assign card_max_pump_override = shape_reg[`RFTX_MAXPUMP_BIT];
  assign normal_residual = shape_reg[`RFTX_RES_MSB:`RFTX_RES_LSB];
  assign shaping_bypass = shape_reg[`RFTX_BYPASS_BIT];
  assign regulator_slew_rate = shape_reg[`RFTX_SLEW_MSB:`RFTX_SLEW_LSB];
  assign fall_time_constant = shape_reg[`RFTX_FALL_MSB:`RFTX_FALL_LSB];
  assign rise_time_constant = shape_reg[`RFTX_RISE_MSB:`RFTX_RISE_LSB];

  // Clock fields
  assign active_load_mod_on = clk_reg[`RFTX_ALM_BIT];
  assign recovered_clock_phase = clk_reg[`RFTX_PHASE_MSB:`RFTX_PHASE_LSB];
  assign prevention_clock_mode = clk_reg[`RFTX_PCLK_MSB:`RFTX_PCLK_LSB];
  assign out2_invert_reader = clk_reg[`RFTX_INV2_RM_BIT];
  assign out2_invert_card = clk_reg[`RFTX_INV2_CM_BIT];
  assign out1_invert_reader = clk_reg[`RFTX_INV1_RM_BIT];
  assign out1_invert_card = clk_reg[`RFTX_INV1_CM_BIT];
  assign reader_clock_mode = clk_reg[`RFTX_RCLK_MSB:`RFTX_RCLK_LSB];
  assign pll_enable = clk_reg[`RFTX_PLL_EN_BIT];

  ////////////////////////////////////////////////////////////////////
  // PLL status

  // Analog status is unrelated to i_mclk, so resynchronise first
  // Costs two cycles of latency on the status bit
  rftx_sync #(
    .W(3)
  ) u_pll_sync (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_async({i_rf_on, i_freq_ok, i_pll_locked}),
    .o_sync(pll_sync)
  );

  // Enabled only with carrier present, frequency good and lock held
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pll_stat_reg <= 1'b0;
    end else begin
      pll_stat_reg <= pll_enable & (&pll_sync);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Gain outputs

  // Chosen static gain and its load pulse
  // Both fields stay readable; only the chosen one reaches gain control
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gain_value <= 10'h000;
      o_gain_load <= 1'b0;
    end else begin
      if (gain_source_select) begin
        o_gain_value <= reader_static_gain;
      end else begin
        o_gain_value <= card_static_gain;
      end
      o_gain_load <= load_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Shaping outputs

  // Amplitude, residual carrier and slew
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_lm_single_driver <= 1'b0;
      o_card_amp <= 2'h0;
      o_card_amp_max <= 1'b0;
      o_residual <= 5'h00;
      o_slew_rate <= 4'h0;
    end else begin
      o_lm_single_driver <= load_mod_driver_select;
      o_card_amp <= card_carrier_amplitude;
      // Max pump wins over the amplitude code while in card mode
      o_card_amp_max <= i_card_mode & card_max_pump_override;
      if (i_prev_active) begin
        o_residual <= overshoot_residual_level;
      end else begin
        o_residual <= normal_residual;
      end
      o_slew_rate <= regulator_slew_rate;
    end
  end

  // Edge time constants; the bypass takes rise control away entirely
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_shaping_bypass <= 1'b0;
      o_fall_tau <= 4'h0;
      o_fall_tau_valid <= 1'b0;
      o_rise_tau <= 4'h0;
      o_rise_tau_valid <= 1'b0;
    end else begin
      o_shaping_bypass <= shaping_bypass;
      o_fall_tau <= fall_time_constant;
      o_fall_tau_valid <= i_single_pump;
      o_rise_tau <= rise_time_constant;
      o_rise_tau_valid <= i_single_pump & ~shaping_bypass;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock outputs

  // Load modulation, phase and PLL enable
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_alm_active <= 1'b0;
      o_clk_phase <= 3'h0;
      o_pll_enable <= 1'b0;
      o_pll_enabled <= 1'b0;
    end else begin
      o_alm_active <= i_card_mode & active_load_mod_on;
      o_clk_phase <= recovered_clock_phase;
      o_pll_enable <= pll_enable;
      o_pll_enabled <= pll_stat_reg;
    end
  end

  // Prevention overrides the clock mode; reader mode otherwise.
  // In card mode without prevention the transmitter is left high
  // impedance, as card drive is owned by the modulation path.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx_clk_mode <= `RFTX_TXST_HIZ;
    end else if (i_prev_active) begin
      o_tx_clk_mode <= prevention_clock_mode;
    end else if (!i_card_mode) begin
      o_tx_clk_mode <= reader_clock_mode;
    end else begin
      o_tx_clk_mode <= `RFTX_TXST_HIZ;
    end
  end

  // First transmit output polarity
  rftx_outsel u_tx1 (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_card_mode(i_card_mode),
    .i_inv_reader(out1_invert_reader),
    .i_inv_card(out1_invert_card),
    .o_invert(o_tx1_invert)
  );

  // Second transmit output polarity
  rftx_outsel u_tx2 (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_card_mode(i_card_mode),
    .i_inv_reader(out2_invert_reader),
    .i_inv_card(out2_invert_card),
    .o_invert(o_tx2_invert)
  );

  ////////////////////////////////////////////////////////////////////
  // Register reads

  // Data valid only in the cycle after the strobe, zero otherwise
  // Status is the registered copy, so a read never sees a half-synced level
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `RFTX_OFS_STATUS: begin
          o_rdata <= {12'h000, pll_stat_reg, 19'h0_0000};
        end
        `RFTX_OFS_GAIN_CFG: begin
          o_rdata <= gain_cfg_reg;
        end
        `RFTX_OFS_GAIN: begin
          o_rdata <= gain_reg;
        end
        `RFTX_OFS_SHAPE: begin
          o_rdata <= shape_reg;
        end
        `RFTX_OFS_CLK: begin
          o_rdata <= clk_reg;
        end
        default: begin
          o_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

//--- verification/rftx_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks for the transmit control bank
module rftx_top_chk (
  // Clock, reset and register port
  input wire i_mclk,
  input wire i_arst_n,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  // Operating state
  input wire i_card_mode,
  input wire i_prev_active,
  input wire i_single_pump,
  // Derived outputs
  input wire [9:0] o_gain_value,
  input wire o_gain_load,
  input wire o_card_amp_max,
  input wire [4:0] o_residual,
  input wire o_rise_tau_valid,
  input wire o_alm_active,
  input wire [2:0] o_tx_clk_mode,
  input wire o_tx1_invert,
  input wire o_tx2_invert
);
  ////////////////////////////////////////
  // Shadow of writable bits; lets outputs be tied to the writes that cause them
  logic [31:0] gn_reg;
  logic [31:0] sh_reg;
  logic [31:0] ck_reg;
  logic sel_reg;
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gn_reg <= 32'h0;
      sh_reg <= 32'h0;
      ck_reg <= 32'h0;
      sel_reg <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == 8'h1F) gn_reg <= i_wdata & 32'h000F_FFFF;
      if (i_addr == 8'h20) sh_reg <= i_wdata & 32'h07FF_FFFF;
      if (i_addr == 8'h21) ck_reg <= i_wdata & 32'h0004_3FFF;
      if (i_addr == 8'h1E) sel_reg <= i_wdata[3];
    end
  end
  // Expected selections, judged one clock later
  wire ld_w = i_wr & (i_addr == 8'h1E) & i_wdata[2];
  wire [2:0] mode_w = i_prev_active ? ck_reg[10:8] : (i_card_mode ? 3'h0 : ck_reg[3:1]);
  wire [1:0] inv_w = i_card_mode ? {ck_reg[6], ck_reg[4]} : {ck_reg[7], ck_reg[5]};
  wire [9:0] gv_w = sel_reg ? gn_reg[19:10] : gn_reg[9:0];
  ////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // Isolated load write, then the one-cycle pulse it causes
  sequence s_load;
    ld_w ##1 !ld_w;
  endsequence
  sequence s_pulse;
    o_gain_load ##1 !o_gain_load;
  endsequence
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  AST_GAIN_LOAD: assert property (s_load |-> ##1 s_pulse)
    else $error("gain load pulse wrong");
  AST_GAIN_SRC: assert property ($past(i_arst_n) |-> o_gain_value == $past(gv_w))
    else $error("gain value source wrong");
  AST_RESIDUAL: assert property ($past(i_arst_n) |->
    o_residual == $past(i_prev_active ? sh_reg[23:19] : sh_reg[17:13]))
    else $error("residual level wrong");
  AST_MAXPUMP: assert property ($past(i_arst_n) |->
    o_card_amp_max == $past(i_card_mode & sh_reg[18]))
    else $error("max pump override wrong");
  AST_RISE_VALID: assert property ($past(i_arst_n) |->
    o_rise_tau_valid == $past(i_single_pump & ~sh_reg[12]))
    else $error("rise constant valid wrong");
  AST_ALM: assert property ($past(i_arst_n) |-> o_alm_active == $past(i_card_mode & ck_reg[18]))
    else $error("active load modulation wrong");
  AST_TX_MODE: assert property ($past(i_arst_n) |-> o_tx_clk_mode == $past(mode_w))
    else $error("transmit clock mode wrong");
  AST_INVERT: assert property ($past(i_arst_n) |-> {o_tx2_invert, o_tx1_invert} == $past(inv_w))
    else $error("output inversion wrong");
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Design inputs, all defined from time zero
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_card_mode = 1'b0;
  logic i_prev_active = 1'b0;
  logic i_single_pump = 1'b0;
  logic i_rf_on = 1'b0;
  logic i_freq_ok = 1'b0;
  logic i_pll_locked = 1'b0;
  // Design outputs
  wire [31:0] o_rdata;
  wire [9:0] o_gain_value;
  wire o_gain_load, o_lm_single_driver, o_card_amp_max, o_shaping_bypass;
  wire [1:0] o_card_amp;
  wire [4:0] o_residual;
  wire [3:0] o_slew_rate, o_fall_tau, o_rise_tau;
  wire o_fall_tau_valid, o_rise_tau_valid, o_alm_active, o_tx1_invert, o_tx2_invert;
  wire [2:0] o_clk_phase, o_tx_clk_mode;
  wire o_pll_enable, o_pll_enabled;
  // Bench state
  int n_fail = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h63A6;
  logic [31:0] exp_q[$];
  logic pend = 1'b0;
  logic [31:0] d;
  logic [7:0] ofs[6] = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22};
  logic [31:0] msk[6] = '{32'h0, 32'h8, 32'h000F_FFFF, 32'h07FF_FFFF, 32'h0004_3FFF, 32'h0};

  rftx_top rftx_top_inst (.*);

  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus slot; every signal assigned once per edge, so slots can run back to back
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, xs());
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0);
  endtask
  // Program both control registers under one mode and check every shaping and clock output except o_pll_enabled
  task automatic derived(input logic [31:0] sh, input logic [31:0] ck, input logic [2:0] m);
    logic cm, pa, sp;
    {cm, pa, sp} = m;
    i_card_mode <= cm;
    i_prev_active <= pa;
    i_single_pump <= sp;
    {i_rf_on, i_freq_ok, i_pll_locked} <= sh[31:29];
    sh = sh & 32'h07FF_FFFF;
    ck = ck & 32'h0004_3FFF;
    bus(1'b1, 1'b0, 8'h20, sh);
    bus(1'b1, 1'b0, 8'h21, ck);
    idle(2);
    #1;
    chk("driver", o_lm_single_driver, sh[26]);
    chk("amplitude", o_card_amp, sh[25:24]);
    chk("slew", {o_shaping_bypass, o_slew_rate}, sh[12:8]);
    chk("tau", {o_fall_tau, o_rise_tau}, sh[7:0]);
    chk("residual", o_residual, pa ? sh[23:19] : sh[17:13]);
    chk("maxpump", o_card_amp_max, cm & sh[18]);
    chk("valid", {o_fall_tau_valid, o_rise_tau_valid}, {sp, sp & ~sh[12]});
    chk("alm", o_alm_active, cm & ck[18]);
    chk("phase", {o_clk_phase, o_pll_enable}, {ck[13:11], ck[0]});
    chk("txmode", o_tx_clk_mode, pa ? ck[10:8] : (cm ? 3'h0 : ck[3:1]));
    chk("invert", {o_tx2_invert, o_tx1_invert}, cm ? {ck[6], ck[4]} : {ck[7], ck[5]});
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Clock at 100 MHz
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  // Read monitor: read data stands only in the cycle after the strobe
  always @(posedge i_mclk) pend <= i_rd;
  always @(negedge i_mclk) begin
    if (pend) chk("rdata", o_rdata, exp_q.pop_front());
  end
  // Watchdog, far beyond the roughly 130 cycles the sequence needs
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    foreach (ofs[k]) rd(ofs[k], 32'h0);
    $display("test reset values done");
    // All ones first to expose reserved bits, then random words, each read back at once
    for (int k = 0; k < 12; k++) begin
      d = (k < 6) ? 32'hFFFF_FFFF : xs();
      bus(1'b1, 1'b0, ofs[k % 6], d);
      rd(ofs[k % 6], d & msk[k % 6]);
    end
    $display("test read write done");
    for (int m = 0; m < 16; m++) derived(xs(), xs(), m[2:0]);
    $display("test derived outputs done");
    // Gain source select and the self-clearing load bit
    for (int s = 0; s < 2; s++) begin
      d = xs();
      bus(1'b1, 1'b0, 8'h1F, d);
      bus(1'b1, 1'b0, 8'h1E, {28'h0, s[0], 3'h4});
      idle(1);
      #1 chk("load", o_gain_load, 1'b1);
      idle(1);
      #1 chk("load", o_gain_load, 1'b0);
      chk("gain", o_gain_value, s[0] ? d[19:10] : d[9:0]);
      rd(8'h1E, {28'h0, s[0], 3'h0});
    end
    $display("test gain done");
    // Status needs enable, carrier, frequency and lock together
    {i_rf_on, i_freq_ok, i_pll_locked} <= 3'h7;
    bus(1'b1, 1'b0, 8'h21, 32'h1);
    idle(6);
    rd(8'h1D, 32'h0008_0000);
    idle(2);
    #1 chk("pll", o_pll_enabled, 1'b1);
    i_pll_locked <= 1'b0;
    idle(6);
    rd(8'h1D, 32'h0);
    idle(3);
    #1 chk("pll", o_pll_enabled, 1'b0);
    $display("test pll status done");
    final_report();
  end
endmodule

bind rftx_top rftx_top_chk rftx_top_chk_inst (.*);
`default_nettype wire
